// File: bia_pkg.sv
// Package: register map, bit positions and reset values for the aggregator
package bia_pkg;

    // Register word indices; the byte address is four times the index
    localparam logic [11:0] BIA_ADDR_STATUS      = 12'hB00;
    localparam logic [11:0] BIA_ADDR_ENABLE      = 12'hB01;
    localparam logic [11:0] BIA_ADDR_EVT_STATUS  = 12'hB48;
    localparam logic [11:0] BIA_ADDR_EVT_MASK    = 12'hB4C;

    // Source status register indices whose read clears a block bit
    localparam logic [11:0] BIA_SRC_ALARM_A      = 12'hB02;
    localparam logic [11:0] BIA_SRC_FRAMER       = 12'hB04;
    localparam logic [11:0] BIA_SRC_SLIP         = 12'hB08;
    localparam logic [11:0] BIA_SRC_LOOP_CODE    = 12'hB0A;
    localparam logic [11:0] BIA_SRC_ALARM_B      = 12'hB0E;
    localparam logic [11:0] BIA_SRC_ALARM_C      = 12'hB40;

    // Bit positions shared by status and enable
    localparam int BIA_BIT_FRAMER      = 0;
    localparam int BIA_BIT_ALARM       = 1;
    localparam int BIA_BIT_SLIP        = 2;
    localparam int BIA_BIT_DATA_LINK   = 3;
    localparam int BIA_BIT_SECOND_TICK = 4;
    localparam int BIA_BIT_CLOCK_LOSS  = 5;
    localparam int BIA_BIT_LOOP_CODE   = 6;
    localparam int BIA_NUM_BLOCKS      = 7;

    // Word index field within the byte address
    localparam int BIA_IDX_LSB         = 2;
    localparam int BIA_IDX_MSB         = 13;

    // Reset values and masks
    localparam logic [7:0]  BIA_STATUS_RESET = 8'h00;
    localparam logic [7:0]  BIA_ENABLE_RESET = 8'h00;
    localparam logic [7:0]  BIA_LIVE_MASK    = 8'h7F;
    localparam logic [31:0] BIA_RDATA_ZERO   = 32'h0000_0000;

    // AHB-Lite encodings
    localparam logic [1:0] BIA_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] BIA_HTRANS_SEQ    = 2'h3;

endpackage : bia_pkg

// File: bia_clr_if.sv
// Interface: clear-on-read strobes from bus slave to pending tracker
`timescale 1ns/100ps
interface bia_clr_if;
    logic [6:0] clr;     // One-cycle clear per block
    logic [6:0] pending; // Current pending bits
    modport slave (output clr, input pending);
    modport tracker (input clr, output pending);
endinterface : bia_clr_if

// File: bia_ahb_slave.sv
// Module: AHB-Lite slave front end, decodes data phase for read/write
`timescale 1ns/100ps
module bia_ahb_slave (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic        hready,
    // Decoded data phase
    output logic             dp_valid,
    output logic             dp_write,
    output logic [11:0]      dp_addr
);
    import bia_pkg::*;

    logic        act_q, act_d;
    logic        wr_q, wr_d;
    logic [11:0] addr_q, addr_d;

    // Capture the address phase when accepted
    always_comb begin
        act_d  = 1'b0;
        wr_d   = wr_q;
        addr_d = addr_q;
        if (hready && hsel && (htrans == BIA_HTRANS_NONSEQ ||
                               htrans == BIA_HTRANS_SEQ)) begin
            act_d  = 1'b1;
            wr_d   = hwrite;
            addr_d = haddr[BIA_IDX_MSB:BIA_IDX_LSB]; // Word index
        end
    end

    // Registered address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            act_q  <= 1'b0;
            wr_q   <= 1'b0;
            addr_q <= 12'h000;
        end else begin
            act_q  <= act_d;
            wr_q   <= wr_d;
            addr_q <= addr_d;
        end
    end

    assign dp_valid = act_q;
    assign dp_write = wr_q;
    assign dp_addr  = addr_q;

endmodule : bia_ahb_slave

// File: bia_pending.sv
// Module: per-block pending flags, set by request, cleared by source read
`timescale 1ns/100ps
module bia_pending (
    // Clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // Request pulses from the blocks
    input  wire logic [6:0] req,
    // Clear strobes and pending view
    bia_clr_if.tracker      cif
);
    import bia_pkg::*;

    logic [6:0] pend_q, pend_d;

    // Set wins over a clear in the same cycle
    always_comb begin
        pend_d = pend_q;
        for (int i = 0; i < BIA_NUM_BLOCKS; i++) begin
            if (req[i]) begin
                pend_d[i] = 1'b1;
            end else if (cif.clr[i]) begin
                pend_d[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_q <= BIA_STATUS_RESET[6:0];
        end else begin
            pend_q <= pend_d;
        end
    end

    assign cif.pending = pend_q;

endmodule : bia_pending

// File: bia_aggregator.sv
// Module: block interrupt aggregator top with AHB-Lite registers
//
// Functional notes
// - Status bit 2 shows a pending slip buffer request; read-only, resets 0.
// - Slip status bit clears after host reads source register B08.
// - Status bit 1 shows a pending alarm/error request; read-only, resets 0.
// - Alarm bit clears after host reads B02, B0E or B40.
// - Status bit 0 shows a pending framer request; read-only, resets 0.
// - Framer bit clears after host reads source register B04.
// - Enable bit 6 gates the loopback code block.
// - Loopback interrupt needs block and source enables both set.
// - Enable bit 5 is the source enable for recovered-clock loss.
// - Enable bit 4 is the source enable for the one-second tick.
// - Enable bit 3 gates the data link block.
// - Data link interrupt needs source and block enables both set.
// - Status bit 6 flags loopback code; clears on read of B0A.
// - Status bit 5 follows clock-loss declaration when detection enabled.
// - Status bit 4 follows the one-second declaration.
// - Status bit 3 flags data link; clears on read of its source.
`timescale 1ns/100ps
module bia_aggregator (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Block request pulses (already source-level gated)
    input  wire logic        slip_req,
    input  wire logic        alarm_req,
    input  wire logic        framer_req,
    input  wire logic        loop_code_req,
    input  wire logic        data_link_req,
    // Levels declared by the receive framer
    input  wire logic        recovered_clock_loss_level,
    input  wire logic        second_tick_level,
    input  wire logic        clock_loss_detect_en,
    // Data link source read strobe (its registers live elsewhere)
    input  wire logic        data_link_src_read,
    // Interrupt outputs
    output logic             irq,
    output logic             evt_irq
);
    import bia_pkg::*;

    bia_clr_if cif ();

    logic        dp_valid;
    logic        dp_write;
    logic [11:0] dp_addr;
    logic        rd_hit;
    logic        wr_hit;
    logic [6:0]  req_vec;
    logic [6:0]  clr_vec;
    logic [7:0]  status;
    logic [7:0]  enable_q, enable_d;
    logic [7:0]  evt_q, evt_d;
    logic [7:0]  evt_mask_q, evt_mask_d;
    logic [7:0]  irq_prev_q, irq_prev_d;
    logic [31:0] rdata_q, rdata_d;
    logic        clk_loss_s1_q, clk_loss_s2_q;
    logic        sec_s1_q, sec_s2_q;
    logic        det_s1_q, det_s2_q;
    logic        irq_q, irq_d;

    // Bus front end
    bia_ahb_slave u_slave (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .hsel     (hsel),
        .haddr    (haddr),
        .htrans   (htrans),
        .hwrite   (hwrite),
        .hready   (hready),
        .dp_valid (dp_valid),
        .dp_write (dp_write),
        .dp_addr  (dp_addr)
    );

    // Pending tracker for the clear-on-read blocks
    bia_pending u_pend (
        .hclk    (hclk),
        .hresetn (hresetn),
        .req     (req_vec),
        .cif     (cif)
    );

    assign rd_hit = dp_valid && !dp_write;
    assign wr_hit = dp_valid && dp_write;

    // Level inputs come from the framer's domain: two-stage synchronise
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_loss_s1_q <= 1'b0;
            clk_loss_s2_q <= 1'b0;
            sec_s1_q      <= 1'b0;
            sec_s2_q      <= 1'b0;
            det_s1_q      <= 1'b0;
            det_s2_q      <= 1'b0;
        end else begin
            clk_loss_s1_q <= recovered_clock_loss_level;
            clk_loss_s2_q <= clk_loss_s1_q;
            sec_s1_q      <= second_tick_level;
            sec_s2_q      <= sec_s1_q;
            det_s1_q      <= clock_loss_detect_en;
            det_s2_q      <= det_s1_q;
        end
    end

    // Requests into the tracker; bits 4 and 5 are levels, not latched
    always_comb begin
        req_vec = 7'h00;
        req_vec[BIA_BIT_FRAMER]    = framer_req;
        req_vec[BIA_BIT_ALARM]     = alarm_req;
        req_vec[BIA_BIT_SLIP]      = slip_req;
        req_vec[BIA_BIT_DATA_LINK] = data_link_req;
        req_vec[BIA_BIT_LOOP_CODE] = loop_code_req;
    end

    // Clears follow the data phase of a read of the source register; bit 3 clears on data_link_src_read
    always_comb begin
        clr_vec = 7'h00;
        clr_vec[BIA_BIT_SLIP] = rd_hit && dp_addr == BIA_SRC_SLIP;
        clr_vec[BIA_BIT_ALARM] = rd_hit &&
            (dp_addr == BIA_SRC_ALARM_A || dp_addr == BIA_SRC_ALARM_B ||
             dp_addr == BIA_SRC_ALARM_C);
        clr_vec[BIA_BIT_FRAMER] = rd_hit &&
            dp_addr == BIA_SRC_FRAMER;
        clr_vec[BIA_BIT_LOOP_CODE] = rd_hit &&
            dp_addr == BIA_SRC_LOOP_CODE;
        clr_vec[BIA_BIT_DATA_LINK] = data_link_src_read;
    end
    assign cif.clr = clr_vec;

    // Status view: latched bits from tracker, levels live
    always_comb begin
        status = {1'b0, cif.pending};
        status[BIA_BIT_CLOCK_LOSS]  = clk_loss_s2_q && det_s2_q;
        status[BIA_BIT_SECOND_TICK] = sec_s2_q;
    end

    // Enable register; bit 7 reserved and held at zero
    always_comb begin
        enable_d = enable_q;
        if (wr_hit && dp_addr == BIA_ADDR_ENABLE) begin
            enable_d = hwdata[7:0] & BIA_LIVE_MASK;
        end
    end

    // Event status: sticky on rising edge of an enabled block line,
    // write one to clear, set wins over clear
    always_comb begin
        irq_prev_d = status & enable_q;
        evt_d      = evt_q;
        if (wr_hit && dp_addr == BIA_ADDR_EVT_STATUS) begin
            evt_d = evt_q & ~hwdata[7:0];
        end
        evt_d = evt_d | (status & enable_q & ~irq_prev_q);
    end

    // Event mask
    always_comb begin
        evt_mask_d = evt_mask_q;
        if (wr_hit && dp_addr == BIA_ADDR_EVT_MASK) begin
            evt_mask_d = hwdata[7:0] & BIA_LIVE_MASK;
        end
    end

    // Interrupt pin: a source needs both of its gates
    always_comb begin
        irq_d = |(status & enable_q & BIA_LIVE_MASK);
    end

    // Read data, registered for the data phase after the address phase
    always_comb begin
        rdata_d = BIA_RDATA_ZERO;
        if (hready && hsel && !hwrite && (htrans == BIA_HTRANS_NONSEQ ||
                                          htrans == BIA_HTRANS_SEQ)) begin
            case (haddr[BIA_IDX_MSB:BIA_IDX_LSB])
                BIA_ADDR_STATUS:     rdata_d[7:0] = status;
                BIA_ADDR_ENABLE:     rdata_d[7:0] = enable_q;
                BIA_ADDR_EVT_STATUS: rdata_d[7:0] = evt_q;
                BIA_ADDR_EVT_MASK:   rdata_d[7:0] = evt_mask_q;
                default:             rdata_d = BIA_RDATA_ZERO;
            endcase
        end
    end

    // Register state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_q   <= BIA_ENABLE_RESET;
            evt_q      <= BIA_STATUS_RESET;
            evt_mask_q <= BIA_STATUS_RESET;
            irq_prev_q <= BIA_STATUS_RESET;
            rdata_q    <= BIA_RDATA_ZERO;
            irq_q      <= 1'b0;
        end else begin
            enable_q   <= enable_d;
            evt_q      <= evt_d;
            evt_mask_q <= evt_mask_d;
            irq_prev_q <= irq_prev_d;
            rdata_q    <= rdata_d;
            irq_q      <= irq_d;
        end
    end

    assign hrdata    = rdata_q;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign irq       = irq_q;
    assign evt_irq   = |(evt_q & evt_mask_q);

    // Assertions
    property p_slip_clear;
        @(posedge hclk) disable iff (!hresetn)
        (rd_hit && dp_addr == BIA_SRC_SLIP && !slip_req)
            |=> !status[BIA_BIT_SLIP];
    endproperty
    a_slip_clear: assert property (p_slip_clear)
        else $error("slip bit not cleared by source read");

    property p_slip_set;
        @(posedge hclk) disable iff (!hresetn)
        slip_req |=> status[BIA_BIT_SLIP];
    endproperty
    a_slip_set: assert property (p_slip_set)
        else $error("slip request not shown");

    property p_alarm_clear;
        @(posedge hclk) disable iff (!hresetn)
        (rd_hit && dp_addr == BIA_SRC_ALARM_C && !alarm_req)
            |=> !status[BIA_BIT_ALARM];
    endproperty
    a_alarm_clear: assert property (p_alarm_clear)
        else $error("alarm bit not cleared");

    property p_framer_hold;
        @(posedge hclk) disable iff (!hresetn)
        (status[BIA_BIT_FRAMER] && !clr_vec[BIA_BIT_FRAMER])
            |=> status[BIA_BIT_FRAMER];
    endproperty
    a_framer_hold: assert property (p_framer_hold)
        else $error("framer bit dropped without read");

    property p_loop_gate;
        @(posedge hclk) disable iff (!hresetn)
        (!enable_q[BIA_BIT_LOOP_CODE] && status == 8'h40) |=> !irq;
    endproperty
    a_loop_gate: assert property (p_loop_gate)
        else $error("loop code passed a closed gate");

    property p_irq_follow;
        @(posedge hclk) disable iff (!hresetn)
        |(status & enable_q) |=> irq;
    endproperty
    a_irq_follow: assert property (p_irq_follow)
        else $error("irq missing for enabled status");

    property p_irq_quiet;
        @(posedge hclk) disable iff (!hresetn)
        (enable_q == 8'h00) ##1 (enable_q == 8'h00) |-> !irq;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet)
        else $error("irq with all blocks disabled");

    property p_enable_write;
        @(posedge hclk) disable iff (!hresetn)
        (wr_hit && dp_addr == BIA_ADDR_ENABLE)
            |=> enable_q == ($past(hwdata[7:0]) & BIA_LIVE_MASK)
                ##1 !enable_q[7];
    endproperty
    a_enable_write: assert property (p_enable_write)
        else $error("enable write not stored");

    property p_tick_level;
        @(posedge hclk) disable iff (!hresetn)
        status[BIA_BIT_SECOND_TICK] == $past(second_tick_level, 2) &&
        status[BIA_BIT_CLOCK_LOSS] ==
            ($past(recovered_clock_loss_level, 2) &&
             $past(clock_loss_detect_en, 2));
    endproperty
    a_tick_level: assert property (p_tick_level)
        else $error("level status mismatch");

endmodule : bia_aggregator

// File: bia_src_model.sv
// Partner model: framer-side source blocks raising block requests
`timescale 1ns/100ps
module bia_src_model (
    // Clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // Bench commands, one bit per source
    input  wire logic [7:0] fire,
    // Requests toward the aggregator
    output logic            framer_req,
    output logic            alarm_req,
    output logic            slip_req,
    output logic            data_link_req,
    output logic            loop_code_req,
    output logic            data_link_src_read
);
    import bia_pkg::*;
    logic [7:0] fire_q;
    logic [7:0] pulse_q;
    // Command edge gives one pulse, as a real source never holds it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fire_q  <= 8'h00;
            pulse_q <= 8'h00;
        end else begin
            fire_q  <= fire;
            pulse_q <= fire & ~fire_q;
        end
    end
    // Bit 7 stands for a read of a data link source register
    assign framer_req         = pulse_q[BIA_BIT_FRAMER];
    assign alarm_req          = pulse_q[BIA_BIT_ALARM];
    assign slip_req           = pulse_q[BIA_BIT_SLIP];
    assign data_link_req      = pulse_q[BIA_BIT_DATA_LINK];
    assign loop_code_req      = pulse_q[BIA_BIT_LOOP_CODE];
    assign data_link_src_read = pulse_q[7];
endmodule : bia_src_model

// File: tb_top.sv
// Testbench: block interrupt aggregator registers and interrupts
`timescale 1ns/100ps
module tb_top;
    import bia_pkg::*;
    // Bus, source and interrupt signals
    logic        hclk    = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel    = 1'b0;
    logic [31:0] haddr   = 32'h0;
    logic [1:0]  htrans  = 2'h0;
    logic        hwrite  = 1'b0;
    logic [2:0]  hsize   = 3'h2;
    logic [31:0] hwdata  = 32'h0;
    logic [7:0]  fire    = 8'h00;
    logic        loss    = 1'b0;
    logic        tick    = 1'b0;
    logic        det_en  = 1'b0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        irq;
    logic        evt_irq;
    logic        s_req;
    logic        a_req;
    logic        f_req;
    logic        l_req;
    logic        d_req;
    logic        d_rd;
    int          n_fail       = 0;
    int          total_checks = 0;
    int          cycles       = 0;
    // Block bit and the source register whose read clears it
    int          blk[7] = '{2, 1, 1, 1, 0, 6, 3};
    logic [11:0] src[7] = '{BIA_SRC_SLIP, BIA_SRC_ALARM_A, BIA_SRC_ALARM_B,
                            BIA_SRC_ALARM_C, BIA_SRC_FRAMER,
                            BIA_SRC_LOOP_CODE, 12'h000};

    always #12.5 hclk = ~hclk;

    bia_aggregator bia_aggregator_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .slip_req(s_req),
        .alarm_req(a_req), .framer_req(f_req), .loop_code_req(l_req),
        .data_link_req(d_req), .recovered_clock_loss_level(loss),
        .second_tick_level(tick), .clock_loss_detect_en(det_en),
        .data_link_src_read(d_rd), .irq(irq), .evt_irq(evt_irq)
    );

    bia_src_model bia_src_model_i (
        .hclk(hclk), .hresetn(hresetn), .fire(fire),
        .framer_req(f_req), .alarm_req(a_req), .slip_req(s_req),
        .data_link_req(d_req), .loop_code_req(l_req),
        .data_link_src_read(d_rd)
    );

    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test

    // A hung handshake ends the run here
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            stop_test();
        end
    end

    task automatic chk_word(string n, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            n_fail++;
        end
    endtask : chk_word

    task automatic chk_bit(string n, logic e, logic g);
        total_checks++;
        if (g !== e) begin
            $display("ERROR %s expected %b seen %b", n, e, g);
            n_fail++;
        end
    endtask : chk_bit

    task automatic idle(int n);
        repeat (n) @(posedge hclk);
    endtask : idle

    // One single AHB-Lite transfer; waits on hready, never a fixed count
    task automatic bus(logic [11:0] a, logic w, logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {18'h0, a, 2'b00};
        htrans <= BIA_HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic wr(logic [11:0] a, logic [31:0] d);
        logic [31:0] t;
        bus(a, 1'b1, d, t);
    endtask : wr

    task automatic rd(logic [11:0] a, output logic [31:0] d);
        bus(a, 1'b0, 32'h0, d);
    endtask : rd

    task automatic pulse(int b);
        @(posedge hclk);
        fire[b] <= 1'b1;
        @(posedge hclk);
        fire[b] <= 1'b0;
        idle(3);
    endtask : pulse

    task automatic t_reset;
        logic [31:0] d;
        rd(BIA_ADDR_STATUS, d);
        chk_word("status reset", 32'h0, d);
        rd(BIA_ADDR_ENABLE, d);
        chk_word("enable reset", 32'h0, d);
        chk_bit("irq reset", 1'b0, irq);
        chk_bit("hresp", 1'b0, hresp);
        wr(BIA_ADDR_ENABLE, 32'hFFFF_FFFF);
        rd(BIA_ADDR_ENABLE, d);
        chk_word("enable rw", 32'h7F, d);
        wr(BIA_ADDR_ENABLE, 32'h0);
        wr(12'hB20, 32'hFF);
        rd(12'hB20, d);
        chk_word("unmapped", 32'h0, d);
    endtask : t_reset

    // Sticky set, gating by block enable, clear on source read
    task automatic t_blocks;
        int          b;
        logic [31:0] d;
        for (int i = 0; i < 7; i++) begin
            b = blk[i];
            pulse(b);
            rd(BIA_ADDR_STATUS, d);
            rd(BIA_ADDR_STATUS, d);
            chk_word("pend", 1 << b, d);
            chk_bit("irq gated", 1'b0, irq);
            wr(BIA_ADDR_ENABLE, 32'h1 << b);
            idle(2);
            chk_bit("irq enabled", 1'b1, irq);
            if (b == BIA_BIT_DATA_LINK)
                pulse(7);
            else
                rd(src[i], d);
            rd(BIA_ADDR_STATUS, d);
            chk_word("clear", 32'h0, d);
            idle(2);
            chk_bit("irq dropped", 1'b0, irq);
            wr(BIA_ADDR_ENABLE, 32'h0);
        end
    endtask : t_blocks

    // Live levels: tick, then clock loss with and without detection
    task automatic t_levels;
        logic [31:0] d;
        tick <= 1'b1;
        loss <= 1'b1;
        idle(6);
        rd(BIA_ADDR_STATUS, d);
        chk_word("tick only", 32'h10, d);
        chk_bit("tick gated", 1'b0, irq);
        wr(BIA_ADDR_ENABLE, 32'h10);
        idle(2);
        chk_bit("tick irq", 1'b1, irq);
        tick   <= 1'b0;
        det_en <= 1'b1;
        idle(6);
        chk_bit("loss gated", 1'b0, irq);
        wr(BIA_ADDR_ENABLE, 32'h20);
        idle(2);
        rd(BIA_ADDR_STATUS, d);
        chk_word("loss", 32'h20, d);
        chk_bit("loss irq", 1'b1, irq);
        loss <= 1'b0;
        idle(6);
        chk_bit("loss gone", 1'b0, irq);
        wr(BIA_ADDR_ENABLE, 32'h0);
    endtask : t_levels

    // Event status: sticky, masked, write one to clear
    task automatic t_events;
        logic [31:0] d;
        wr(BIA_ADDR_EVT_STATUS, 32'h7F);
        wr(BIA_ADDR_ENABLE, 32'h04);
        pulse(BIA_BIT_SLIP);
        rd(BIA_ADDR_EVT_STATUS, d);
        chk_word("event set", 32'h04, d);
        chk_bit("event masked", 1'b0, evt_irq);
        wr(BIA_ADDR_EVT_MASK, 32'h04);
        idle(2);
        chk_bit("event irq", 1'b1, evt_irq);
        wr(BIA_ADDR_EVT_STATUS, 32'h04);
        idle(2);
        chk_bit("event cleared", 1'b0, evt_irq);
        rd(BIA_SRC_SLIP, d);
        wr(BIA_ADDR_EVT_MASK, 32'h0);
    endtask : t_events

    // Reset in mid-run drops pending work and enables
    task automatic t_midreset;
        logic [31:0] d;
        wr(BIA_ADDR_ENABLE, 32'h41);
        pulse(BIA_BIT_LOOP_CODE);
        chk_bit("irq pre rst", 1'b1, irq);
        hresetn <= 1'b0;
        idle(3);
        hresetn <= 1'b1;
        rd(BIA_ADDR_STATUS, d);
        chk_word("status rerst", 32'h0, d);
        rd(BIA_ADDR_ENABLE, d);
        chk_word("enable rerst", 32'h0, d);
        chk_bit("irq rerst", 1'b0, irq);
    endtask : t_midreset

    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_blocks();
        t_levels();
        t_events();
        t_midreset();
        stop_test();
    end
endmodule : tb_top
